// ### include/ifd_params.svh
// offsets, reset values and field positions of the input decoder
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH
`define IFD_ADDR_W 4
`define IFD_DATA_W 32
`define IFD_TERMS 6
`define IFD_IDX_FAST_A 4
`define IFD_IDX_FAST_B 5
`define IFD_ADDR_FAST_TYPE 4'h0
`define IFD_ADDR_FUNC_BASE 4'h1
`define IFD_ADDR_FUNC_LAST 4'h6
`define IFD_ADDR_CMD_SRC 4'h7
`define IFD_ADDR_CTRL 4'h8
`define IFD_ADDR_GEAR1 4'h9
`define IFD_ADDR_GEAR2 4'hA
`define IFD_ADDR_PULSE_RATE 4'hB
`define IFD_ADDR_ESTOP_TIME 4'hC
`define IFD_ADDR_STATUS 4'hD
`define IFD_ADDR_ENERGY 4'hE
`define IFD_ADDR_POSITION 4'hF
`define IFD_FAST_TYPE_RST 8'h00
`define IFD_FAST_A_BIT 0
`define IFD_FAST_B_BIT 4
`define IFD_FUNC1_RST 8'h01
`define IFD_FUNC2_RST 8'h04
`define IFD_FUNC3_RST 8'h07
`define IFD_FUNC_OTHER_RST 8'h00
`define IFD_CTRL_PID_POL_BIT 0
`define IFD_CTRL_FAULT_CLR_BIT 1
`define IFD_GEAR_RST 16'h0001
`define IFD_RATE_RST 16'h0000
`define IFD_ESTOP_RST 16'h0000
`endif

// ### include/ifd_pkg.sv
// types shared by the input function decoder
package ifd_pkg;
  typedef enum logic [7:0]
  {
    IFD_FN_NONE = 8'h00,
    IFD_FN_CMD_TERM = 8'h25,
    IFD_FN_CMD_COMM = 8'h26,
    IFD_FN_PRE_EXCITE = 8'h27,
    IFD_FN_ENERGY_CLR = 8'h28,
    IFD_FN_ENERGY_HOLD = 8'h29,
    IFD_FN_ESTOP = 8'h38,
    IFD_FN_OVER_TEMP = 8'h39,
    IFD_FN_VF_MODE = 8'h3B,
    IFD_FN_VECTOR_MODE = 8'h3C,
    IFD_FN_PID_INVERT = 8'h3D,
    IFD_FN_POS_CLR = 8'h42,
    IFD_FN_PULSE_UP = 8'h43,
    IFD_FN_PULSE_EN = 8'h44,
    IFD_FN_PULSE_DOWN = 8'h45,
    IFD_FN_GEAR2 = 8'h46,
    IFD_FN_MASTER = 8'h47,
    IFD_FN_SLAVE = 8'h48
  } ifd_func_code_type;
  typedef enum logic [4:0]
  {
    HIT_CMD_TERM = 5'h00, HIT_CMD_COMM = 5'h01, HIT_PRE_EXCITE = 5'h02,
    HIT_ENERGY_CLR = 5'h03, HIT_ENERGY_HOLD = 5'h04, HIT_ESTOP = 5'h05,
    HIT_OVER_TEMP = 5'h06, HIT_VF_MODE = 5'h07, HIT_VECTOR_MODE = 5'h08,
    HIT_PID_INVERT = 5'h09, HIT_POS_CLR = 5'h0A, HIT_PULSE_UP = 5'h0B,
    HIT_PULSE_EN = 5'h0C, HIT_PULSE_DOWN = 5'h0D, HIT_GEAR2 = 5'h0E,
    HIT_MASTER = 5'h0F, HIT_SLAVE = 5'h10
  } ifd_hit_type;
  localparam int IFD_HITS = 17;
  typedef enum logic [1:0]
  {
    SRC_KEYPAD = 2'b00,
    SRC_TERMINAL = 2'b01,
    SRC_COMM = 2'b10
  } ifd_cmd_src_type;
  typedef enum logic
  {
    MODE_VF = 1'b0,
    MODE_VECTOR = 1'b1
  } ifd_ctrl_mode_type;
  typedef enum logic
  {
    ROLE_MASTER = 1'b0,
    ROLE_SLAVE = 1'b1
  } ifd_role_type;
endpackage : ifd_pkg

// ### logic/ifd_func_hits.sv
// maps each active terminal's function code onto one hit bit per function
`timescale 1ns/10ps
`default_nettype none
`include "ifd_params.svh"
module ifd_func_hits
  import ifd_pkg::*;
(
  input wire logic [7:0] termCode [`IFD_TERMS],
  input wire logic [`IFD_TERMS-1:0] termActive,
  output logic [IFD_HITS-1:0] hits
);
  always_comb
  begin
    hits = '0;
    for (int t = 0; t < `IFD_TERMS; t++)
    begin
      if (termActive[t])
      begin
        case (termCode[t])
          IFD_FN_CMD_TERM: hits[HIT_CMD_TERM] = 1'b1;
          IFD_FN_CMD_COMM: hits[HIT_CMD_COMM] = 1'b1;
          IFD_FN_PRE_EXCITE: hits[HIT_PRE_EXCITE] = 1'b1;
          IFD_FN_ENERGY_CLR: hits[HIT_ENERGY_CLR] = 1'b1;
          IFD_FN_ENERGY_HOLD: hits[HIT_ENERGY_HOLD] = 1'b1;
          IFD_FN_ESTOP: hits[HIT_ESTOP] = 1'b1;
          IFD_FN_OVER_TEMP: hits[HIT_OVER_TEMP] = 1'b1;
          IFD_FN_VF_MODE: hits[HIT_VF_MODE] = 1'b1;
          IFD_FN_VECTOR_MODE: hits[HIT_VECTOR_MODE] = 1'b1;
          IFD_FN_PID_INVERT: hits[HIT_PID_INVERT] = 1'b1;
          IFD_FN_POS_CLR: hits[HIT_POS_CLR] = 1'b1;
          IFD_FN_PULSE_UP: hits[HIT_PULSE_UP] = 1'b1;
          IFD_FN_PULSE_EN: hits[HIT_PULSE_EN] = 1'b1;
          IFD_FN_PULSE_DOWN: hits[HIT_PULSE_DOWN] = 1'b1;
          IFD_FN_GEAR2: hits[HIT_GEAR2] = 1'b1;
          IFD_FN_MASTER: hits[HIT_MASTER] = 1'b1;
          IFD_FN_SLAVE: hits[HIT_SLAVE] = 1'b1;
          // no function, reserved and undefined codes ask for nothing
          default: ;
        endcase
      end
    end
  end
endmodule : ifd_func_hits
`default_nettype wire

// ### logic/ifd_decoder.sv
// terminal function decoder with its register file
`timescale 1ns/10ps
`default_nettype none
`include "ifd_params.svh"
// What this block does
// - while code 37 active, run source is terminal; else previous source
// - while code 38 active, run source is communication; else previous
// - code 39 requests pre-excitation for as long as it is active
// - code 40 becoming active clears the energy counter
// - code 41 active freezes the energy counter
// - code 56 active requests emergency stop over the set decel time
// - code 57 active raises over-temperature fault and stops the motor
// - code 59 selects V/F control, only while stopped
// - code 60 selects closed-loop vector control, only while stopped
// - code 61 inverts PID polarity together with the polarity setting
// - code 66 active clears the position count
// - code 67 active adds pulses at the superimposed pulse rate
// - code 69 active subtracts pulses at the superimposed pulse rate
// - pulse add and subtract act only while code 68 is active
// - code 70 active selects the second gear numerator
// - code 71 selects master role, only while stopped
// - code 72 selects slave role, only while stopped
// - type setting ones digit: fast input A pulse (0) or digital (1)
// - type setting tens digit: fast input B pulse (0) or digital (1)
// - each terminal has a function select; 0 none, first defaults 1
module ifd_decoder
  import ifd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`IFD_TERMS-1:0] termPin,
  input wire logic driveStopped,
  input wire logic energyValid,
  input wire logic [15:0] energyDelta,
  input wire logic posStepValid,
  input wire logic posStepDown,
  input wire logic [`IFD_ADDR_W-1:0] regAddr,
  input wire logic [`IFD_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`IFD_DATA_W-1:0] regRdData,
  output logic [1:0] runSource,
  output logic preExcite,
  output logic emergencyStop,
  output logic [15:0] emergencyDecelTime,
  output logic overTempFault,
  output logic motorStopReq,
  output logic controlMode,
  output logic pidInvert,
  output logic superPulseUp,
  output logic superPulseDown,
  output logic [15:0] gearNumerator,
  output logic slaveRole,
  output logic fastPulseA,
  output logic fastPulseB,
  output logic [31:0] energyCount,
  output logic [31:0] positionCount
);
  logic [`IFD_TERMS-1:0] pinMeta_r;
  logic [`IFD_TERMS-1:0] pinSync_r;
  logic [7:0] fastType_r;
  logic [7:0] funcSel_r [`IFD_TERMS];
  logic [1:0] baseSource_r;
  logic pidPolCfg_r;
  logic [15:0] gear1_r;
  logic [15:0] gear2_r;
  logic [15:0] pulseRate_r;
  logic [15:0] pulseCnt_r;
  logic [`IFD_TERMS-1:0] termActive;
  logic [IFD_HITS-1:0] hits;
  logic [IFD_HITS-1:0] hits_r;
  logic energyClrPrev_r;
  logic faultClear;
  logic pulseDir;
  logic pulseOn;
  logic [3:0] funcIdx;

  // a write to the type setting keeps only the two digit bits
  function automatic logic [7:0] typeFilter(input logic [7:0] v);
    typeFilter = '0;
    typeFilter[`IFD_FAST_A_BIT] = v[`IFD_FAST_A_BIT];
    typeFilter[`IFD_FAST_B_BIT] = v[`IFD_FAST_B_BIT];
  endfunction : typeFilter

  // bus signals go in as arguments so the assign re-evaluates on them
  function automatic logic isWrite(input logic w,
    input logic [`IFD_ADDR_W-1:0] a, input logic [`IFD_ADDR_W-1:0] b);
    isWrite = w && (a == b);
  endfunction : isWrite

  assign funcIdx = regAddr - `IFD_ADDR_FUNC_BASE;
  assign faultClear = isWrite(regWrite, regAddr, `IFD_ADDR_CTRL)
    && regWrData[`IFD_CTRL_FAULT_CLR_BIT];

  // terminal pins are asynchronous to the core clock
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end
    else
    begin
      pinMeta_r <= termPin;
      pinSync_r <= pinMeta_r;
    end
  end

  // fast inputs decode functions only when set up as digital inputs
  always_comb
  begin
    termActive = pinSync_r;
    termActive[`IFD_IDX_FAST_A] = pinSync_r[`IFD_IDX_FAST_A]
      && fastType_r[`IFD_FAST_A_BIT];
    termActive[`IFD_IDX_FAST_B] = pinSync_r[`IFD_IDX_FAST_B]
      && fastType_r[`IFD_FAST_B_BIT];
  end

  ifd_func_hits funcHits
  (
    .termCode(funcSel_r),
    .termActive(termActive),
    .hits(hits)
  );

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hits_r <= '0;
      energyClrPrev_r <= 1'b0;
    end
    else
    begin
      hits_r <= hits;
      energyClrPrev_r <= hits_r[HIT_ENERGY_CLR];
    end
  end

  // register writes
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fastType_r <= `IFD_FAST_TYPE_RST;
      funcSel_r[0] <= `IFD_FUNC1_RST;
      funcSel_r[1] <= `IFD_FUNC2_RST;
      funcSel_r[2] <= `IFD_FUNC3_RST;
      for (int t = 3; t < `IFD_TERMS; t++)
      begin
        funcSel_r[t] <= `IFD_FUNC_OTHER_RST;
      end
      baseSource_r <= SRC_KEYPAD;
      pidPolCfg_r <= 1'b0;
      gear1_r <= `IFD_GEAR_RST;
      gear2_r <= `IFD_GEAR_RST;
      pulseRate_r <= `IFD_RATE_RST;
      emergencyDecelTime <= `IFD_ESTOP_RST;
    end
    else if (regWrite)
    begin
      if (regAddr == `IFD_ADDR_FAST_TYPE)
      begin
        fastType_r <= typeFilter(regWrData[7:0]);
      end
      else if (regAddr >= `IFD_ADDR_FUNC_BASE
        && regAddr <= `IFD_ADDR_FUNC_LAST)
      begin
        funcSel_r[funcIdx[2:0]] <= regWrData[7:0];
      end
      else if (regAddr == `IFD_ADDR_CMD_SRC)
      begin
        baseSource_r <= regWrData[1:0];
      end
      else if (regAddr == `IFD_ADDR_CTRL)
      begin
        pidPolCfg_r <= regWrData[`IFD_CTRL_PID_POL_BIT];
      end
      else if (regAddr == `IFD_ADDR_GEAR1)
      begin
        gear1_r <= regWrData[15:0];
      end
      else if (regAddr == `IFD_ADDR_GEAR2)
      begin
        gear2_r <= regWrData[15:0];
      end
      else if (regAddr == `IFD_ADDR_PULSE_RATE)
      begin
        pulseRate_r <= regWrData[15:0];
      end
      else if (regAddr == `IFD_ADDR_ESTOP_TIME)
      begin
        emergencyDecelTime <= regWrData[15:0];
      end
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdData <= '0;
    end
    else if (!regRead)
    begin
      regRdData <= '0;
    end
    else if (regAddr == `IFD_ADDR_FAST_TYPE)
    begin
      regRdData <= {24'h000000, fastType_r};
    end
    else if (regAddr >= `IFD_ADDR_FUNC_BASE
      && regAddr <= `IFD_ADDR_FUNC_LAST)
    begin
      regRdData <= {24'h000000, funcSel_r[funcIdx[2:0]]};
    end
    else if (regAddr == `IFD_ADDR_CMD_SRC)
    begin
      regRdData <= {30'h00000000, baseSource_r};
    end
    else if (regAddr == `IFD_ADDR_CTRL)
    begin
      regRdData <= {31'h00000000, pidPolCfg_r};
    end
    else if (regAddr == `IFD_ADDR_GEAR1)
    begin
      regRdData <= {16'h0000, gear1_r};
    end
    else if (regAddr == `IFD_ADDR_GEAR2)
    begin
      regRdData <= {16'h0000, gear2_r};
    end
    else if (regAddr == `IFD_ADDR_PULSE_RATE)
    begin
      regRdData <= {16'h0000, pulseRate_r};
    end
    else if (regAddr == `IFD_ADDR_ESTOP_TIME)
    begin
      regRdData <= {16'h0000, emergencyDecelTime};
    end
    else if (regAddr == `IFD_ADDR_STATUS)
    begin
      regRdData <= {10'h000, slaveRole, controlMode, overTempFault,
        runSource, hits_r};
    end
    else if (regAddr == `IFD_ADDR_ENERGY)
    begin
      regRdData <= energyCount;
    end
    else
    begin
      regRdData <= positionCount;
    end
  end

  // run source override; terminal wins if both are asserted
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      runSource <= SRC_KEYPAD;
    end
    else if (hits_r[HIT_CMD_TERM])
    begin
      runSource <= SRC_TERMINAL;
    end
    else if (hits_r[HIT_CMD_COMM])
    begin
      runSource <= SRC_COMM;
    end
    else
    begin
      runSource <= baseSource_r;
    end
  end

  // level requests follow their terminal directly
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      preExcite <= 1'b0;
      emergencyStop <= 1'b0;
      pidInvert <= 1'b0;
      gearNumerator <= `IFD_GEAR_RST;
      fastPulseA <= 1'b0;
      fastPulseB <= 1'b0;
    end
    else
    begin
      preExcite <= hits_r[HIT_PRE_EXCITE];
      emergencyStop <= hits_r[HIT_ESTOP];
      pidInvert <= pidPolCfg_r ^ hits_r[HIT_PID_INVERT];
      gearNumerator <= hits_r[HIT_GEAR2] ? gear2_r : gear1_r;
      fastPulseA <= pinSync_r[`IFD_IDX_FAST_A]
        && !fastType_r[`IFD_FAST_A_BIT];
      fastPulseB <= pinSync_r[`IFD_IDX_FAST_B]
        && !fastType_r[`IFD_FAST_B_BIT];
    end
  end

  // fault stays latched after the input drops; set beats clear
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      overTempFault <= 1'b0;
      motorStopReq <= 1'b0;
    end
    else
    begin
      if (hits_r[HIT_OVER_TEMP])
      begin
        overTempFault <= 1'b1;
      end
      else if (faultClear)
      begin
        overTempFault <= 1'b0;
      end
      motorStopReq <= hits_r[HIT_OVER_TEMP] || overTempFault;
    end
  end

  // mode and role change only in the stopped state
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      controlMode <= MODE_VF;
      slaveRole <= ROLE_MASTER;
    end
    else if (driveStopped)
    begin
      if (hits_r[HIT_VF_MODE] && !hits_r[HIT_VECTOR_MODE])
      begin
        controlMode <= MODE_VF;
      end
      else if (hits_r[HIT_VECTOR_MODE] && !hits_r[HIT_VF_MODE])
      begin
        controlMode <= MODE_VECTOR;
      end
      if (hits_r[HIT_MASTER] && !hits_r[HIT_SLAVE])
      begin
        slaveRole <= ROLE_MASTER;
      end
      else if (hits_r[HIT_SLAVE] && !hits_r[HIT_MASTER])
      begin
        slaveRole <= ROLE_SLAVE;
      end
    end
  end

  // energy: clear on the activating edge, then hold or accumulate
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      energyCount <= '0;
    end
    else if (hits_r[HIT_ENERGY_CLR] && !energyClrPrev_r)
    begin
      energyCount <= '0;
    end
    else if (hits_r[HIT_ENERGY_HOLD])
    begin
      energyCount <= energyCount;
    end
    else if (energyValid)
    begin
      energyCount <= energyCount + {16'h0000, energyDelta};
    end
  end

  // add and subtract together cancel out
  assign pulseOn = hits_r[HIT_PULSE_EN]
    && (hits_r[HIT_PULSE_UP] != hits_r[HIT_PULSE_DOWN]);
  assign pulseDir = hits_r[HIT_PULSE_UP];

  // one pulse every pulseRate_r cycles; zero rate gives none
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pulseCnt_r <= '0;
      superPulseUp <= 1'b0;
      superPulseDown <= 1'b0;
    end
    else if (!pulseOn || pulseRate_r == 16'h0000)
    begin
      pulseCnt_r <= '0;
      superPulseUp <= 1'b0;
      superPulseDown <= 1'b0;
    end
    else if (pulseCnt_r >= pulseRate_r - 16'h0001)
    begin
      pulseCnt_r <= '0;
      superPulseUp <= pulseDir;
      superPulseDown <= !pulseDir;
    end
    else
    begin
      pulseCnt_r <= pulseCnt_r + 16'h0001;
      superPulseUp <= 1'b0;
      superPulseDown <= 1'b0;
    end
  end

  // position count; superimposed pulses count only in cycles without a position step
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      positionCount <= '0;
    end
    else if (hits_r[HIT_POS_CLR])
    begin
      positionCount <= '0;
    end
    else if (posStepValid || superPulseUp || superPulseDown)
    begin
      if (posStepValid && posStepDown)
      begin
        positionCount <= positionCount - 32'h00000001;
      end
      else if (posStepValid)
      begin
        positionCount <= positionCount + 32'h00000001;
      end
      else if (superPulseUp)
      begin
        positionCount <= positionCount + 32'h00000001;
      end
      else
      begin
        positionCount <= positionCount - 32'h00000001;
      end
    end
  end
endmodule : ifd_decoder
`default_nettype wire

// ### bench/ifd_decoder_properties.sv
// port-level assertions for the terminal function decoder
`timescale 1ns/10ps
`default_nettype none
`include "ifd_params.svh"
module ifd_decoder_properties
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic driveStopped,
  input wire logic energyValid,
  input wire logic [15:0] energyDelta,
  input wire logic [`IFD_ADDR_W-1:0] regAddr,
  input wire logic [`IFD_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [`IFD_DATA_W-1:0] regRdData,
  input wire logic [15:0] emergencyDecelTime,
  input wire logic overTempFault,
  input wire logic motorStopReq,
  input wire logic controlMode,
  input wire logic superPulseUp,
  input wire logic superPulseDown,
  input wire logic slaveRole,
  input wire logic fastPulseA,
  input wire logic [31:0] energyCount,
  input wire logic [31:0] positionCount
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // shadow of the fast input A type bit, seen from the bus
  logic digA_r;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      digA_r <= 1'b0;
    else if (regWrite && regAddr == `IFD_ADDR_FAST_TYPE)
      digA_r <= regWrData[`IFD_FAST_A_BIT];
  end
  property p_rd_idle;
    !$past(regRead) |-> regRdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_mode_stop;
    $changed(controlMode) |-> $past(driveStopped);
  endproperty
  a_mode_stop: assert property (p_mode_stop)
    else $error("control mode changed while running");
  property p_role_stop;
    $changed(slaveRole) |-> $past(driveStopped);
  endproperty
  a_role_stop: assert property (p_role_stop)
    else $error("role changed while running");
  property p_pulse_excl;
    !(superPulseUp && superPulseDown);
  endproperty
  a_pulse_excl: assert property (p_pulse_excl)
    else $error("pulse up and down together");
  property p_pos_step;
    $changed(positionCount) |-> positionCount == 32'h0 ||
      positionCount == $past(positionCount) + 32'h1 ||
      positionCount == $past(positionCount) - 32'h1;
  endproperty
  a_pos_step: assert property (p_pos_step)
    else $error("position jumped");
  property p_energy_step;
    $changed(energyCount) |-> energyCount == 32'h0 || ($past(energyValid)
      && energyCount == $past(energyCount) + {16'h0, $past(energyDelta)});
  endproperty
  a_energy_step: assert property (p_energy_step)
    else $error("energy count jumped");
  property p_fault_stop;
    $rose(overTempFault) |-> ##[0:1] motorStopReq;
  endproperty
  a_fault_stop: assert property (p_fault_stop)
    else $error("fault without stop request");
  property p_fault_hold;
    $fell(overTempFault) |-> $past(regWrite) &&
      $past(regAddr) == `IFD_ADDR_CTRL && $past(regWrData[1]);
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault dropped without clear");
  property p_decel;
    regWrite && regAddr == `IFD_ADDR_ESTOP_TIME |=>
      emergencyDecelTime == $past(regWrData[15:0]);
  endproperty
  a_decel: assert property (p_decel)
    else $error("decel time not taken");
  property p_fast_a;
    digA_r && $past(digA_r) && $past(digA_r, 2) |-> !fastPulseA;
  endproperty
  a_fast_a: assert property (p_fast_a)
    else $error("fast input A pulses in digital mode");
  c_up: cover property (superPulseUp);
  c_down: cover property (superPulseDown);
  c_fault: cover property ($rose(overTempFault));
  c_mode: cover property ($rose(controlMode));
endmodule : ifd_decoder_properties
bind ifd_decoder ifd_decoder_properties u_props (
  .core_clk, .rstn, .driveStopped, .energyValid, .energyDelta, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .emergencyDecelTime,
  .overTempFault, .motorStopReq, .controlMode, .superPulseUp,
  .superPulseDown, .slaveRole, .fastPulseA, .energyCount, .positionCount
);
`default_nettype wire

// ### bench/ifd_terminal_model.sv
// external switches driving the terminal pins
`timescale 1ns/10ps
`default_nettype none
`include "ifd_params.svh"
module ifd_terminal_model
(
  input wire logic core_clk,
  output var logic [`IFD_TERMS-1:0] pins
);
  initial pins = '0;
  // contacts may chatter before settling; the decoder has no filter and passes it through
  task automatic press(input int idx, input logic lvl, input int bounce);
    @(posedge core_clk);
    repeat (bounce)
    begin
      pins[idx] <= lvl;
      @(posedge core_clk);
      pins[idx] <= !lvl;
      @(posedge core_clk);
    end
    pins[idx] <= lvl;
  endtask : press
endmodule : ifd_terminal_model
`default_nettype wire

// ### bench/test_ifd_decoder.sv
// self-checking bench for the terminal function decoder
`timescale 1ns/10ps
`default_nettype none
`include "ifd_params.svh"
module test_ifd_decoder import ifd_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic driveStopped = 1'b1;
  logic energyValid = 1'b0;
  logic [15:0] energyDelta = 16'h0000;
  logic posStepValid = 1'b0;
  logic posStepDown = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [5:0] termPin;
  logic [31:0] regRdData, energyCount, positionCount, outs, v, eng, pos;
  logic [1:0] runSource;
  logic [15:0] emergencyDecelTime, gearNumerator, g2;
  logic preExcite, emergencyStop, overTempFault, motorStopReq, controlMode;
  logic pidInvert, superPulseUp, superPulseDown, slaveRole;
  logic fastPulseA, fastPulseB, mode, role, flt;
  logic [7:0] c;
  logic [1:0] base, rs;
  logic [31:0] seed = 32'h0000DC91;
  logic [7:0] codes [21] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h38,
    8'h39, 8'h3B, 8'h3C, 8'h3D, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
    8'h48, 8'h2A, 8'h49, 8'h4F, 8'h00};
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int up, dn;
  assign outs = {7'h0, motorStopReq, runSource, preExcite, emergencyStop,
    overTempFault,
    controlMode, pidInvert, slaveRole, gearNumerator};
  ifd_terminal_model term (.core_clk, .pins(termPin));
  ifd_decoder uut (.core_clk, .rstn, .termPin, .driveStopped, .energyValid,
    .energyDelta, .posStepValid, .posStepDown, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .runSource, .preExcite, .emergencyStop,
    .emergencyDecelTime, .overTempFault, .motorStopReq, .controlMode,
    .pidInvert, .superPulseUp, .superPulseDown, .gearNumerator, .slaveRole,
    .fastPulseA, .fastPulseB, .energyCount, .positionCount);
  initial forever #2 core_clk = ~core_clk;
  // whole run is well under this; reaching it means a hang
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : check
  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rdc(input string n, input logic [3:0] a,
    input logic [31:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check(n, e, regRdData);
    @(posedge core_clk);
  endtask : rdc
  task automatic pin(input int i, input logic l);
    term.press(i, l, 0);
    repeat (6) @(posedge core_clk);
  endtask : pin
  // random energy and position traffic, mirrored in the model
  task automatic stim(input int n, input logic hold);
    logic [31:0] d;
    repeat (n)
    begin
      d = rnd();
      energyValid <= d[0];
      energyDelta <= d[31:16];
      posStepValid <= d[1];
      posStepDown <= d[2];
      eng = (d[0] && !hold) ? eng + {16'h0, d[31:16]} : eng;
      pos = d[1] ? (d[2] ? pos - 32'h1 : pos + 32'h1) : pos;
      @(posedge core_clk);
    end
    energyValid <= 1'b0;
    posStepValid <= 1'b0;
    @(posedge core_clk);
  endtask : stim
  task automatic pulses();
    up = 0;
    dn = 0;
    repeat (50)
    begin
      @(posedge core_clk);
      #1 up += superPulseUp;
      dn += superPulseDown;
    end
  endtask : pulses
  initial
  begin
    eng = 32'h0;
    pos = 32'h0;
    {mode, role, flt} = 3'b000;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdc("type", 4'h0, 32'h00);
    rdc("fn1", 4'h1, 32'h01);
    rdc("fn4", 4'h4, 32'h00);
    wr(4'h0, 32'hFF);
    rdc("typeMask", 4'h0, 32'h11);
    wr(4'h0, 32'h00);
    g2 = 16'(rnd());
    wr(4'hA, {16'h0, g2});
    v = rnd();
    wr(4'hC, v);
    check("decel", {16'h0, v[15:0]}, {16'h0, emergencyDecelTime});
    for (int i = 0; i < 21; i++)
    begin
      c = codes[i];
      base = (c == 8'h25) ? 2'b10 : 2'b01;
      wr(4'h7, {30'h0, base});
      wr(4'h2, {24'h0, c});
      pin(1, 1'b1);
      rs = (c == 8'h25) ? 2'b01 : (c == 8'h26) ? 2'b10 : base;
      mode = (c == 8'h3B) ? 1'b0 : (c == 8'h3C) ? 1'b1 : mode;
      role = (c == 8'h47) ? 1'b0 : (c == 8'h48) ? 1'b1 : role;
      flt = flt | (c == 8'h39);
      rdc("hits", 4'hD, {10'h0, role, mode, flt, rs,
        (i < 17) ? 17'h1 << i : 17'h0});
      check("on", {7'h0, flt, rs, c == 8'h27, c == 8'h38, flt, mode,
        c == 8'h3D,
        role, (c == 8'h46) ? g2 : 16'h0001}, outs);
      pin(1, 1'b0);
      check("off", {7'h0, flt, base, 2'b00, flt, mode, 1'b0, role,
        16'h0001},
        outs);
      if (flt)
        wr(4'h8, 32'h2);
      flt = 1'b0;
    end
    driveStopped <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      wr(4'h2, k ? 32'h47 : 32'h3B);
      pin(1, 1'b1);
      check("run", 2'b11, {controlMode, slaveRole});
      pin(1, 1'b0);
    end
    driveStopped <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr(4'(5 + k), 32'h27);
      for (int t = 0; t < 2; t++)
      begin
        wr(4'h0, t ? (k ? 32'h10 : 32'h01) : 32'h0);
        pin(4 + k, 1'b1);
        check("fast", {t == 1, t == 0},
          {preExcite, k ? fastPulseB : fastPulseA});
        pin(4 + k, 1'b0);
      end
    end
    wr(4'h3, 32'h28);
    wr(4'h4, 32'h29);
    stim(30, 1'b0);
    wr(4'hE, 32'h5A5A);
    rdc("energy", 4'hE, eng);
    pin(3, 1'b1);
    stim(30, 1'b1);
    check("hold", eng, energyCount);
    pin(3, 1'b0);
    pin(2, 1'b1);
    eng = 32'h0;
    stim(20, 1'b0);
    check("clear", eng, energyCount);
    pin(2, 1'b0);
    rdc("pos", 4'hF, pos);
    wr(4'h4, 32'h42);
    pin(3, 1'b1);
    check("posClr", 32'h0, positionCount);
    pin(3, 1'b0);
    wr(4'hB, 32'h5);
    wr(4'h1, 32'h44);
    wr(4'h2, 32'h43);
    wr(4'h3, 32'h45);
    pin(1, 1'b1);
    pulses();
    check("noEnable", 32'h0, up);
    term.press(0, 1'b1, 3);
    repeat (10) @(posedge core_clk);
    pulses();
    check("up", 32'd10, up);
    check("upNoDown", 32'd0, dn);
    pin(2, 1'b1);
    pulses();
    check("cancel", 32'h0, up + dn);
    pin(1, 1'b0);
    pulses();
    check("down", 32'd10, dn);
    check("downNoUp", 32'd0, up);
    end_sim();
  end
endmodule : test_ifd_decoder
`default_nettype wire
